// ==== rtl/scs_pkg.sv ====
package scs_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned MAX_BITS = 16;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int unsigned CONV_TIME_NS = 50_000;
    localparam int unsigned CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    // One spare slot keeps the final decision inside the limit
    localparam int unsigned BIT_CYCLES = CONV_CYCLES / (MAX_BITS + 1);
    localparam int unsigned CNT_W = 7;
    localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);

    // ****************************************
    // Register map
    // ****************************************
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_RESULT = 8'h08;
    localparam int unsigned CTRL_BIPOLAR = 0;
    localparam int unsigned CTRL_TWOS = 1;
    localparam int unsigned STAT_EOC = 0;
    localparam int unsigned STAT_VALID = 1;
    localparam int unsigned STAT_SAMPLE = 2;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic twos;
        logic bipolar;
    } scs_cfg_s;

    typedef struct packed {
        logic [15:0] data;
        logic oe_hi;
        logic oe_lo;
    } scs_bus_s;

    typedef enum logic {
        ST_IDLE,
        ST_CONV
    } scs_state_e;

endpackage : scs_pkg

// ==== rtl/scs_sequencer.sv ====
// Notes on behaviour
// (RULE1) Trigger high keeps the sample/hold stage sampling.
// (RULE2) With sample/hold in use, host holds trigger high 5 us minimum.
// (RULE3) Without sample/hold, host trigger pulse lasts 1 us minimum.
// (RULE4) Host may tie trigger to sample/hold control as one signal.
// (RULE5) Trigger fall: hold, reset conversion logic, start converting.
// (RULE6) Any new trigger fall aborts and restarts a running conversion.
// (RULE7) Conversion start sets MSB, clears all other result bits.
// (RULE8) End-of-conversion rises at start, stays high whole conversion.
// (RULE9) Bits tried MSB first, each set on an internal clock edge.
// (RULE10) Comparator of feedback code against held input decides each bit.
// (RULE11) One internal clock cycle per bit, as many cycles as bits.
// (RULE12) Whole conversion finishes within 50 us of the trigger fall.
// (RULE13) End-of-conversion falls after the last bit decision.
// (RULE14) Result reaches the bus only through enabled tri-state drivers.
// (RULE15) Host should read old result while next input is acquired.
// (RULE16) Host should switch channels on a sample/hold control edge.
// (RULE17) Unipolar 14/15-bit result is straight binary.
// (RULE18) Bipolar 14/15-bit: offset binary or two's complement, by config.
// (RULE19) Unipolar 16-bit result is modified binary.
// (RULE20) Bipolar 16-bit result is two's complement only.
// (RULE21) Modified binary is straight binary with MSB inverted.
// (RULE22) Separate high and low byte enables gate their own byte.
// (RULE23) Resolution is a build parameter; bit period fits time limit.
// (RULE24) Trigger high pauses conversion; end-of-conversion unchanged.
//
// Our own choices: the address map and the APB interface to the registers.
module scs_sequencer #(
    parameter int unsigned RESOLUTION = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic trigger,
    input wire logic comparator_high,
    input wire logic high_byte_output_enable,
    input wire logic low_byte_output_enable,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [scs_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic sample_mode,
    output logic end_of_conversion,
    output logic [15:0] dac_code,
    output scs_pkg::scs_bus_s result_bus
);

    // ****************************************
    // Result coding
    // ****************************************
    // Two's complement equals offset binary; only the MSB sense differs
    function automatic logic [15:0] scs_code(
        input logic [15:0] raw,
        input scs_pkg::scs_cfg_s cfg
    );
        logic [15:0] val;
        val = raw;
        if (RESOLUTION == 16)
            val[15] = ~raw[15]; // RULE19 RULE20 RULE21
        else if (cfg.bipolar && cfg.twos)
            val[RESOLUTION-1] = ~raw[RESOLUTION-1]; // RULE18
        return val; // RULE17
    endfunction : scs_code

    localparam logic [3:0] MSB_IDX = 4'(RESOLUTION - 1); // RULE23

    // ****************************************
    // Register read decode
    // ****************************************
    // Status bits gathered in one word for the read path
    function automatic logic [31:0] scs_status(
        input logic sample,
        input logic valid,
        input logic eoc
    );
        logic [31:0] word;
        word = 32'h0000_0000;
        word[scs_pkg::STAT_EOC] = eoc;
        word[scs_pkg::STAT_VALID] = valid;
        word[scs_pkg::STAT_SAMPLE] = sample;
        return word;
    endfunction : scs_status

    // Unmapped offsets read zero so a stray read shows no stale data
    function automatic logic [31:0] scs_read(
        input logic [scs_pkg::ADDR_W-1:0] addr,
        input scs_pkg::scs_cfg_s cfg,
        input logic [31:0] status,
        input logic [15:0] result
    );
        logic [31:0] word;
        word = 32'h0000_0000;
        case (addr)
            scs_pkg::ADDR_CTRL:
            begin
                word[1:0] = cfg;
            end
            scs_pkg::ADDR_STATUS:
            begin
                word = status;
            end
            scs_pkg::ADDR_RESULT:
            begin
                word[15:0] = result;
            end
            default:
            begin
                word = 32'h0000_0000;
            end
        endcase
        return word;
    endfunction : scs_read

    // ****************************************
    // State
    // ****************************************
    scs_pkg::scs_state_e state_q, state_d;
    scs_pkg::scs_cfg_s cfg_q;

    logic trig_q;
    logic sample_q;

    logic eoc_q, eoc_d;
    logic valid_q, valid_d;
    logic [15:0] sar_q, sar_d;
    logic [3:0] idx_q, idx_d;
    logic [scs_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [15:0] result_q, result_d;

    scs_pkg::scs_bus_s bus_q;

    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    wire logic trig_fall = trig_q & ~trigger;
    wire logic bit_end = cnt_q == scs_pkg::BIT_LAST;
    wire logic [15:0] coded = scs_code(result_q, cfg_q);

    // ****************************************
    // Successive approximation
    // ****************************************
    always_comb
    begin
        state_d = state_q;
        eoc_d = eoc_q;
        valid_d = valid_q;
        sar_d = sar_q;
        idx_d = idx_q;
        cnt_d = cnt_q;
        result_d = result_q;
        case (state_q)
            scs_pkg::ST_IDLE:
            begin
                // Nothing runs until the trigger falls
                state_d = scs_pkg::ST_IDLE;
            end
            scs_pkg::ST_CONV:
            begin
                if (!trigger && !bit_end) // RULE24
                begin
                    cnt_d = cnt_q + 1'b1; // RULE11
                end
                else if (!trigger)
                begin
                    cnt_d = '0;
                    if (comparator_high)
                    begin
                        sar_d[idx_q] = 1'b0; // RULE10
                    end
                    if (idx_q == 4'h0)
                    begin
                        state_d = scs_pkg::ST_IDLE;
                        eoc_d = 1'b0; // RULE13 RULE12
                        valid_d = 1'b1;
                        result_d = sar_d;
                    end
                    else
                    begin
                        idx_d = idx_q - 1'b1;
                        sar_d[idx_q - 1'b1] = 1'b1; // RULE9
                    end
                end
            end
            default:
            begin
                state_d = scs_pkg::ST_IDLE;
            end
        endcase
        // A fall overrides all above: restart wins over a finishing bit
        if (trig_fall)
        begin
            state_d = scs_pkg::ST_CONV; // RULE5 RULE6
            sar_d = 16'h0000;
            sar_d[MSB_IDX] = 1'b1; // RULE7
            idx_d = MSB_IDX;
            cnt_d = '0;
            eoc_d = 1'b1; // RULE8
            valid_d = 1'b0;
            result_d = result_q;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= scs_pkg::ST_IDLE;
            trig_q <= 1'b0;
            sample_q <= 1'b0;
            eoc_q <= 1'b0;
            valid_q <= 1'b0;
            sar_q <= 16'h0000;
            idx_q <= 4'h0;
            cnt_q <= '0;
            result_q <= scs_pkg::RESULT_RESET;
        end
        else if (clk_en)
        begin
            state_q <= state_d;
            trig_q <= trigger;
            sample_q <= trigger; // RULE1 RULE4
            eoc_q <= eoc_d;
            valid_q <= valid_d;
            sar_q <= sar_d;
            idx_q <= idx_d;
            cnt_q <= cnt_d;
            result_q <= result_d;
        end
    end

    // ****************************************
    // Byte-gated output drivers
    // ****************************************
    // Enables lag the host's enables by one clock; data is stable then
    wire logic result_ready = valid_q & ~eoc_q; // RULE14
    wire logic drive_hi = high_byte_output_enable & result_ready; // RULE22
    wire logic drive_lo = low_byte_output_enable & result_ready; // RULE22

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            bus_q <= '0;
        else if (clk_en)
        begin
            bus_q.data <= coded;
            bus_q.oe_hi <= drive_hi; // RULE14 RULE22
            bus_q.oe_lo <= drive_lo; // RULE14 RULE22
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    wire logic setup = psel & ~penable & ~pready_q;
    wire logic access = psel & penable & pready_q;
    wire logic hit_ctrl = paddr == scs_pkg::ADDR_CTRL;
    wire logic hit_stat = paddr == scs_pkg::ADDR_STATUS;
    wire logic hit_res = paddr == scs_pkg::ADDR_RESULT;
    wire logic mapped = hit_ctrl | hit_stat | hit_res;
    // Registered answer: pready never follows paddr combinationally
    wire logic [31:0] stat_word = scs_status(sample_q, valid_q, eoc_q);
    wire logic [31:0] rd_word = scs_read(paddr, cfg_q, stat_word, coded);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_q <= scs_pkg::CTRL_RESET;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else if (clk_en)
        begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            if (setup)
                prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
            if (access && pwrite && hit_ctrl)
            begin
                cfg_q.bipolar <= pwdata[scs_pkg::CTRL_BIPOLAR];
                cfg_q.twos <= pwdata[scs_pkg::CTRL_TWOS];
            end
        end
    end

    // ****************************************
    // Pin outputs
    // ****************************************
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign sample_mode = sample_q;
    assign end_of_conversion = eoc_q;
    assign dac_code = sar_q;
    assign result_bus = bus_q;

endmodule : scs_sequencer

// ==== verification/scs_adc_model.sv ====
module scs_adc_model (
    input wire logic clk,
    input wire logic sample_mode,
    input wire logic [15:0] dac_code,
    input wire logic [15:0] vin,
    output logic comparator_high
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] held_q = 16'h0000;
    // Held value freezes on hold, so late input changes do not leak in
    always @(posedge clk)
        if (sample_mode) held_q <= vin;
    assign comparator_high = dac_code > held_q;
endmodule : scs_adc_model

// ==== verification/scs_sequencer_checker.sv ====
module scs_checker #(
    parameter int unsigned RESOLUTION = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic trigger,
    input wire logic sample_mode,
    input wire logic end_of_conversion,
    input wire logic [15:0] dac_code,
    input wire logic high_byte_output_enable,
    input wire logic low_byte_output_enable,
    input wire scs_pkg::scs_bus_s result_bus
);
    timeunit 1ns;
    timeprecision 1ps;
    // Slack of a few clocks for the edge detect and result register
    localparam int unsigned LO = RESOLUTION * scs_pkg::BIT_CYCLES - 4;
    logic [10:0] cnt_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Counts converting clocks; trigger high pauses it like the design
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn) cnt_q <= '0;
        else if ($fell(trigger)) cnt_q <= '0;
        else if (end_of_conversion && !trigger) cnt_q <= cnt_q + 1'b1;
    end
    AST_SAMPLE: assert property (trigger |=> sample_mode)
        else $error("sample lost");
    AST_HOLD: assert property ($fell(trigger) |=> !sample_mode)
        else $error("no hold");
    AST_START: assert property ($fell(trigger) |=>
        end_of_conversion && dac_code == 16'(1) << (RESOLUTION - 1))
        else $error("bad start");
    AST_STEADY: assert property (end_of_conversion && cnt_q < LO |=>
        end_of_conversion) else $error("early end");
    AST_LEN: assert property ($fell(end_of_conversion) |->
        cnt_q >= LO && cnt_q <= scs_pkg::CONV_CYCLES) else $error("length");
    AST_OE_HI: assert property (result_bus.oe_hi |->
        $past(high_byte_output_enable) && !$past(end_of_conversion))
        else $error("high byte");
    AST_OE_LO: assert property (result_bus.oe_lo |->
        $past(low_byte_output_enable) && !$past(end_of_conversion))
        else $error("low byte");
    AST_OE_OFF: assert property (end_of_conversion |=>
        !result_bus.oe_hi && !result_bus.oe_lo) else $error("bus driven");
    AST_PAUSE: assert property (trigger |=>
        $stable(end_of_conversion)) else $error("no pause");
endmodule : scs_checker
bind scs_sequencer scs_checker #(.RESOLUTION(RESOLUTION)) u_chk (
    .clk(clk), .resetn(resetn), .trigger(trigger),
    .sample_mode(sample_mode), .end_of_conversion(end_of_conversion),
    .dac_code(dac_code), .result_bus(result_bus),
    .high_byte_output_enable(high_byte_output_enable),
    .low_byte_output_enable(low_byte_output_enable));

// ==== verification/scs_sequencer_tb.sv ====
module sar_conversion_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetn = 1'b0, trigger = 1'b0, hi_en = 1'b0;
    logic lo_en = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic clk_en = 1'b1;
    logic pready, pslverr, smode, eoc, cmp, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] vin = 16'h0000, dac;
    logic [33:0] r;
    scs_pkg::scs_bus_s rbus;
    int err_count = 0;
    int num_checks = 0;
    // Row: input code, byte enables, expected coded result
    logic [33:0] rows [4] = '{{16'h0000, 2'h3, 16'h8000},
        {16'hFFFF, 2'h2, 16'h7FFF}, {16'h8000, 2'h1, 16'h0000},
        {16'h1234, 2'h0, 16'h9234}};
    scs_sequencer dut (.clk(clk), .resetn(resetn), .clk_en(clk_en),
        .trigger(trigger), .comparator_high(cmp),
        .high_byte_output_enable(hi_en), .low_byte_output_enable(lo_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_mode(smode), .end_of_conversion(eoc),
        .dac_code(dac), .result_bus(rbus));
    scs_adc_model u_adc (.clk(clk), .sample_mode(smode), .dac_code(dac),
        .vin(vin), .comparator_high(cmp));
    initial forever #12.5 clk = ~clk;
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // Trigger also acts as sample control: one signal does both
    task automatic pulse(input logic [15:0] v);
        vin <= v;
        trigger <= 1'b1;
        repeat (200) @(posedge clk);
        trigger <= 1'b0;
    endtask : pulse
    task automatic done;
        repeat (3) @(posedge clk);
        for (int n = 0; n < 3000 && eoc !== 1'b0; n++) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask : done
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test
    initial
    begin
        #1ms;
        err_count++;
        stop_test();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk({eoc, smode, rbus}, 34'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h3);
        foreach (rows[i])
        begin
            r = rows[i];
            hi_en <= r[17];
            lo_en <= r[16];
            pulse(r[33:18]);
            done();
            chk(rbus, {r[15:0], r[17:16]});
        end
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h9234);
        apb(1'b0, 8'h0C, 32'h0);
        chk({er, rd}, 34'h1_0000_0000);
        hi_en <= 1'b1;
        lo_en <= 1'b1;
        pulse(16'h00FF);
        repeat (600) @(posedge clk);
        chk({eoc, rbus.oe_hi, rbus.oe_lo}, 34'h4);
        pulse(16'h4321);
        done();
        chk(rbus, {16'hC321, 2'h3});
        vin <= 16'h1111;
        trigger <= 1'b1;
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'hC321);
        repeat (200) @(posedge clk);
        trigger <= 1'b0;
        repeat (50) @(posedge clk);
        clk_en <= 1'b0;
        @(posedge clk);
        r = {eoc, dac};
        repeat (150) @(posedge clk);
        chk({eoc, dac}, r);
        clk_en <= 1'b1;
        resetn <= 1'b0;
        @(posedge clk);
        chk({eoc, rbus}, 34'h0);
        stop_test();
    end
endmodule : sar_conversion_sequencer_tb
